// File: rtl/tofcp_defines.vh
/*
 * Constants for the time-of-flight imager control-page register bank:
 * register offsets, field positions, reset values and the serial address prefix.
 * Assumes it is included by its bare name from the design files under rtl/.
 */
`ifndef TOFCP_DEFINES_VH
`define TOFCP_DEFINES_VH

// ==========================================================================
// Register offsets
`define TOFCP_ADDR_FAMILY     8'h00
`define TOFCP_ADDR_REVISION   8'h01
`define TOFCP_ADDR_NVM_ADDR   8'h11
`define TOFCP_ADDR_NVM_DATA   8'h12
`define TOFCP_ADDR_STRAP      8'h20
`define TOFCP_ADDR_F1_SEL     8'h22
`define TOFCP_ADDR_F1_MOD     8'h24

// ==========================================================================
// Field positions and masks
`define TOFCP_STRAP_LOW_BIT   5
`define TOFCP_STRAP_HIGH_BIT  6
`define TOFCP_F1_SEL_WMASK    8'h3f

// ==========================================================================
// Reset and default values
`define TOFCP_NVM_RESET       8'h00
`define TOFCP_STRAP_RESET     8'h00
`define TOFCP_F1_SEL_RESET    8'h30
`define TOFCP_F1_MOD_RESET    8'h00

// ==========================================================================
// Serial device address: fixed upper five bits, two strap bits below them
`define TOFCP_DEV_PREFIX      5'h08

`endif

// File: rtl/tofcp_regs.v
/*
 * Control-page register bank of a time-of-flight imager, reached over a
 * serial two-wire slave port: identification, indirect EEPROM access,
 * strap scan and the first-frame sample and modulation registers.
 * Assumes one 10 MHz clock, a synchronous active-high reset held for at
 * least four clocks, and frame signals from logic on the same clock.
 */
`timescale 1ns/100ps
`include "tofcp_defines.vh"
module tofcp_regs #(
	parameter [7:0] FAMILY_ID   = 8'h5a,	// Arbitrary value.
	parameter [7:0] REVISION_ID = 8'h01	// Arbitrary value.
) (
	input  wire       clock,	// System clock.
	input  wire       rst,	// Synchronous reset, active high.
	input  wire       scl_in,	// Serial clock pin level.
	input  wire       sda_in,	// Serial data pin level.
	output reg        sda_out,	// Serial data drive value, always low.
	output reg        sda_oe,	// High while pulling serial data low.
	input  wire       address_strap_low,	// Low address strap pin.
	input  wire       address_strap_high,	// High address strap pin.
	input  wire       frame_active,	// High while a frame is acquired.
	input  wire       frame_start,	// Pulse at the start of a frame.
	input  wire       program_loaded,	// Pulse when the sequencer program is in.
	input  wire       nvm_load,	// Pulse: EEPROM read byte is ready.
	input  wire [7:0] nvm_load_data,	// EEPROM read byte.
	output reg  [7:0] nvm_address,	// Indirect EEPROM location.
	output reg  [7:0] nvm_data,	// Indirect EEPROM data byte.
	output reg        nvm_data_written,	// Pulse after a host write of the data byte.
	output wire [1:0] correlation_sample_first,	// Sample for the first pair.
	output wire [1:0] correlation_sample_second,	// Sample for the second pair.
	output wire [1:0] background_suppression,	// Suppression code in use.
	output reg  [7:0] modulation_control,	// Modulation control in use.
	output reg        defaults_valid	// High once the defaults hold.
);
	// ======================================================================
	// Serial engine states
	localparam [2:0] ST_IDLE  = 3'h0;
	localparam [2:0] ST_ADDR  = 3'h1;
	localparam [2:0] ST_REG   = 3'h2;
	localparam [2:0] ST_WDATA = 3'h3;
	localparam [2:0] ST_ACK   = 3'h4;
	localparam [2:0] ST_RDATA = 3'h5;
	localparam [2:0] ST_RACK  = 3'h6;

	wire       scl_s;
	wire       sda_s;
	wire       strap_low_s;
	wire       strap_high_s;
	reg        scl_q;
	reg        sda_q;
	reg  [2:0] state;
	reg  [2:0] ack_next;
	reg  [3:0] bitcnt;
	reg  [7:0] shift;
	reg  [7:0] tx;
	reg  [7:0] pointer;
	reg        nack;
	reg        wr_en;
	reg  [7:0] wr_addr;
	reg  [7:0] wr_data;
	reg        rst_q;
	reg  [7:0] strap_scan;
	reg  [7:0] sel_host;
	reg  [7:0] mod_host;
	reg  [7:0] sel_act;
	reg  [7:0] next_sel;
	reg  [7:0] next_mod;
	wire [7:0] rd_now;
	wire [6:0] dev_addr;
	wire       start;
	wire       stop;
	wire       scl_rise;
	wire       scl_fall;

	// ======================================================================
	// Pin synchronisers
	tofcp_sync #(
		.WIDTH(4)
	) u_sync (
		.clock(clock),
		.din  ({address_strap_high, address_strap_low, sda_in, scl_in}),
		.dout ({strap_high_s, strap_low_s, sda_s, scl_s})
	);

	// Bus events, seen on the filtered levels only.
	assign start    = scl_s & scl_q & sda_q & ~sda_s;
	assign stop     = scl_s & scl_q & ~sda_q & sda_s;
	assign scl_rise = scl_s & ~scl_q;
	assign scl_fall = ~scl_s & scl_q;
	assign dev_addr = {`TOFCP_DEV_PREFIX, strap_scan[`TOFCP_STRAP_HIGH_BIT],
		strap_scan[`TOFCP_STRAP_LOW_BIT]};

	// ======================================================================
	// Read decode
	// Unlisted addresses read zero, so a stray read never shows stale state.
	function [7:0] rd_mux;
		input [7:0] a;
		begin
			case (a)
				`TOFCP_ADDR_FAMILY:   rd_mux = FAMILY_ID;
				`TOFCP_ADDR_REVISION: rd_mux = REVISION_ID;
				`TOFCP_ADDR_NVM_ADDR: rd_mux = nvm_address;
				`TOFCP_ADDR_NVM_DATA: rd_mux = nvm_data;
				`TOFCP_ADDR_STRAP:    rd_mux = strap_scan;
				`TOFCP_ADDR_F1_SEL:   rd_mux = sel_host;
				`TOFCP_ADDR_F1_MOD:   rd_mux = mod_host;
				default:              rd_mux = 8'h00;
			endcase
		end
	endfunction

	assign rd_now = rd_mux(pointer);

	// ======================================================================
	// Serial slave engine
	// Data is changed only on a falling clock edge, so the master never
	// sees the line move while its clock is high.
	always @(posedge clock) begin
		scl_q <= scl_s;
		sda_q <= sda_s;
		if (rst) begin
			state    <= ST_IDLE;
			ack_next <= ST_IDLE;
			bitcnt   <= 4'h0;
			shift    <= 8'h00;
			tx       <= 8'h00;
			pointer  <= 8'h00;
			nack     <= 1'b0;
			wr_en    <= 1'b0;
			wr_addr  <= 8'h00;
			wr_data  <= 8'h00;
			sda_out  <= 1'b0;
			sda_oe   <= 1'b0;
		end else begin
			wr_en <= 1'b0;
			if (start) begin
				state  <= ST_ADDR;
				bitcnt <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop) begin
				state  <= ST_IDLE;
				sda_oe <= 1'b0;
			end else if (scl_rise) begin
				if (state == ST_ADDR || state == ST_REG || state == ST_WDATA) begin
					shift  <= {shift[6:0], sda_s};
					bitcnt <= bitcnt + 4'h1;
				end else if (state == ST_RACK) begin
					nack <= sda_s;
				end
			end else if (scl_fall) begin
				case (state)
					ST_ADDR: begin
						if (bitcnt == 4'h8) begin
							if (shift[7:1] == dev_addr) begin
								sda_oe   <= 1'b1;
								state    <= ST_ACK;
								ack_next <= shift[0] ? ST_RDATA : ST_REG;
							end else begin
								state <= ST_IDLE;
							end
						end
					end
					ST_REG: begin
						if (bitcnt == 4'h8) begin
							pointer  <= shift;
							sda_oe   <= 1'b1;
							state    <= ST_ACK;
							ack_next <= ST_WDATA;
						end
					end
					ST_WDATA: begin
						if (bitcnt == 4'h8) begin
							wr_en    <= 1'b1;
							wr_addr  <= pointer;
							wr_data  <= shift;
							pointer  <= pointer + 8'h01;
							sda_oe   <= 1'b1;
							state    <= ST_ACK;
							ack_next <= ST_WDATA;
						end
					end
					ST_ACK: begin
						bitcnt <= 4'h0;
						state  <= ack_next;
						sda_oe <= 1'b0;
						if (ack_next == ST_RDATA) begin
							sda_oe  <= ~rd_now[7];
							tx      <= {rd_now[6:0], 1'b0};
							pointer <= pointer + 8'h01;
							bitcnt  <= 4'h1;
						end
					end
					ST_RDATA: begin
						if (bitcnt == 4'h8) begin
							sda_oe <= 1'b0;
							state  <= ST_RACK;
						end else begin
							sda_oe <= ~tx[7];
							tx     <= {tx[6:0], 1'b0};
							bitcnt <= bitcnt + 4'h1;
						end
					end
					ST_RACK: begin
						if (nack) begin
							state <= ST_IDLE;
						end else begin
							sda_oe  <= ~rd_now[7];
							tx      <= {rd_now[6:0], 1'b0};
							pointer <= pointer + 8'h01;
							bitcnt  <= 4'h1;
							state   <= ST_RDATA;
						end
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// ======================================================================
	// Next host copies of the shadowed registers
	// Writes to the identification codes and reserved addresses fall
	// through here untouched, so they can never corrupt the bank.
	always @* begin
		next_sel = sel_host;
		next_mod = mod_host;
		if (program_loaded) begin
			next_sel = `TOFCP_F1_SEL_RESET;
			next_mod = `TOFCP_F1_MOD_RESET;
		end else if (wr_en) begin
			if (wr_addr == `TOFCP_ADDR_F1_SEL) begin
				next_sel = wr_data & `TOFCP_F1_SEL_WMASK;
			end
			if (wr_addr == `TOFCP_ADDR_F1_MOD) begin
				next_mod = wr_data;
			end
		end
	end

	// ======================================================================
	// Register storage
	// Only documented locations hold state, so a reset returns everything,
	// reserved space included, to factory contents.
	always @(posedge clock) begin
		rst_q <= rst;
		if (rst) begin
			nvm_address        <= `TOFCP_NVM_RESET;
			nvm_data           <= `TOFCP_NVM_RESET;
			nvm_data_written   <= 1'b0;
			strap_scan         <= `TOFCP_STRAP_RESET;
			sel_host           <= `TOFCP_F1_SEL_RESET;
			mod_host           <= `TOFCP_F1_MOD_RESET;
			sel_act            <= `TOFCP_F1_SEL_RESET;
			modulation_control <= `TOFCP_F1_MOD_RESET;
			defaults_valid     <= 1'b0;
		end else begin
			nvm_data_written <= 1'b0;
			// Straps are caught once, on the first clock after release.
			if (rst_q) begin
				strap_scan <= {1'b0, strap_high_s, strap_low_s, 5'h00};
			end
			if (program_loaded) begin
				defaults_valid <= 1'b1;
			end
			if (wr_en && !program_loaded) begin
				if (wr_addr == `TOFCP_ADDR_NVM_ADDR) begin
					nvm_address <= wr_data;
				end
				if (wr_addr == `TOFCP_ADDR_NVM_DATA) begin
					nvm_data         <= wr_data;
					nvm_data_written <= 1'b1;
				end
			end
			// An EEPROM byte arriving with a host write wins the cycle.
			if (nvm_load) begin
				nvm_data <= nvm_load_data;
			end
			sel_host <= next_sel;
			mod_host <= next_mod;
			// Active copies move only between frames or as one begins.
			if (!frame_active || frame_start) begin
				sel_act            <= next_sel;
				modulation_control <= next_mod;
			end
		end
	end

	// ======================================================================
	// Field outputs of the active selection register
	assign correlation_sample_first  = sel_act[1:0];
	assign correlation_sample_second = sel_act[3:2];
	assign background_suppression    = sel_act[5:4];
endmodule

// File: rtl/tofcp_sync.v
/*
 * Pin input synchroniser: three chain flip-flops per bit, and the registered output follows
 * a bit only once the second and third stages agree.
 * Assumes asynchronous inputs and one clock; it carries no reset on purpose.
 */
`timescale 1ns/100ps
module tofcp_sync #(
	parameter WIDTH = 1
) (
	input  wire             clock,	// System clock.
	input  wire [WIDTH-1:0] din,	// Asynchronous pin levels.
	output reg  [WIDTH-1:0] dout	// Filtered synchronous levels.
);
	reg [WIDTH-1:0] stage1;
	reg [WIDTH-1:0] stage2;
	reg [WIDTH-1:0] stage3;

	// ======================================================================
	// Chain and agreement filter
	// Running free through reset lets the straps settle before release.
	always @(posedge clock) begin
		stage1 <= din;
		stage2 <= stage1;
		stage3 <= stage2;
		dout   <= (stage2 & stage3) | (dout & (stage2 | stage3));
	end
endmodule

// File: verif/tof_control_page_registers_bench.sv
/*
 * Self-checking bench for the control-page register bank.
 * Assumes the host model and the bound checker are compiled alongside.
 */
`timescale 1ns/100ps
`include "tofcp_defines.vh"
module tof_control_page_registers_bench;
	localparam [7:0] FAM = 8'hc3;	// Arbitrary value.
	localparam [7:0] REV = 8'h27;	// Arbitrary value.
	reg         clock, rst, address_strap_low, address_strap_high, frame_active, frame_start;
	reg         program_loaded, nvm_load;
	reg  [7:0]  nvm_load_data, v, m, na, nd;
	reg  [31:0] d, seed;
	reg  [6:0]  dev;
	wire        scl, sda_low, sda_oe, nvm_data_written, defaults_valid;
	wire [1:0]  first, second, supp;
	wire [7:0]  nvm_address, nvm_data, modulation_control;
	integer     failures, samples_checked, nvm_writes, i;
	// Open-drain data line with a pull-up.
	wire        sda = !(sda_oe || sda_low);
	// ====================
	// Harness
	always #50 clock = !clock;
	tofcp_regs #(.FAMILY_ID(FAM), .REVISION_ID(REV)) u_dut (
		.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
		.address_strap_low(address_strap_low), .address_strap_high(address_strap_high),
		.frame_active(frame_active), .frame_start(frame_start),
		.program_loaded(program_loaded), .nvm_load(nvm_load), .nvm_load_data(nvm_load_data),
		.nvm_address(nvm_address), .nvm_data(nvm_data), .nvm_data_written(nvm_data_written),
		.correlation_sample_first(first), .correlation_sample_second(second),
		.background_suppression(supp), .modulation_control(modulation_control),
		.defaults_valid(defaults_valid));
	tofcp_host u_host (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
	// Counting pulses catches both a missing and a doubled write strobe.
	always @(posedge clock)
		if (nvm_data_written === 1'b1)
			nvm_writes = nvm_writes + 1;
	task check(input [7:0] got, input [7:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task rd(input [7:0] ra, input [7:0] exp);
		u_host.read_seq(dev, ra, 1, d);
		check(d[7:0], exp);
	endtask
	task wr(input [7:0] ra, input [7:0] val);
		u_host.write_seq(dev, ra, {24'h0, val}, 1);
	endtask
	// Straps change as reset rises and settle within it; the pin moves after release
	// to show that it is caught only once.
	task do_reset();
		address_strap_low <= $random(seed);
		address_strap_high <= $random(seed);
		rst <= 1'b1;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		dev = {`TOFCP_DEV_PREFIX, address_strap_high, address_strap_low};
		repeat (6) @(posedge clock);
		address_strap_low <= !address_strap_low;
	endtask
	task complete_run();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ====================
	// Tests
	initial begin
		seed = 32'h0e89adb7;
		clock = 1'b0;
		rst = 1'b1;
		{frame_active, frame_start, program_loaded, nvm_load} = 4'h0;
		{address_strap_low, address_strap_high} = 2'b00;
		nvm_load_data = 8'h00;
		failures = 0;
		samples_checked = 0;
		nvm_writes = 0;
		do_reset();
		u_host.read_seq(dev, 8'h00, 2, d);
		check(d[7:0], FAM);
		check(d[15:8], REV);
		wr(8'h00, ~FAM);
		wr(8'h01, ~REV);
		rd(8'h00, FAM);
		rd(8'h01, REV);
		rd(8'h20, {1'b0, dev[1:0], 5'h00});
		rd(8'h22, 8'h30);
		check({7'h00, defaults_valid}, 8'h00);
		$display("test identification done");
		for (i = 0; i < 4; i = i + 1) begin
			v = $random(seed);
			v[5:0] = {i[1:0], ~i[1:0], i[1:0]};
			m = $random(seed);
			wr(8'h22, v);
			wr(8'h24, m);
			rd(8'h22, v & 8'h3f);
			check({2'b00, supp, second, first}, {2'b00, v[5:0]});
			check(modulation_control, m);
		end
		@(posedge clock) program_loaded <= 1'b1;
		@(posedge clock) program_loaded <= 1'b0;
		repeat (3) @(posedge clock);
		check({7'h00, defaults_valid}, 8'h01);
		check({2'b00, supp, second, first}, 8'h30);
		check(modulation_control, 8'h00);
		$display("test field codes done");
		frame_active <= 1'b1;
		v = 8'h0f | ($random(seed) & 8'h30);
		m = $random(seed) | 8'h01;
		wr(8'h22, v);
		wr(8'h24, m);
		check({2'b00, supp, second, first}, 8'h30);
		check(modulation_control, 8'h00);
		rd(8'h22, v);
		@(posedge clock) frame_start <= 1'b1;
		@(posedge clock) frame_start <= 1'b0;
		repeat (3) @(posedge clock);
		check({2'b00, supp, second, first}, v);
		check(modulation_control, m);
		frame_active <= 1'b0;
		$display("test shadow done");
		na = $random(seed);
		nd = $random(seed);
		u_host.write_seq(dev, 8'h11, {16'h0000, nd, na}, 2);
		check(nvm_address, na);
		check(nvm_data, nd);
		check(nvm_writes[7:0], 8'h01);
		@(posedge clock);
		nvm_load <= 1'b1;
		nvm_load_data <= ~nd;
		@(posedge clock) nvm_load <= 1'b0;
		rd(8'h12, ~nd);
		rd(8'h11, na);
		$display("test indirect access done");
		u_host.write_seq(dev ^ 7'h01, 8'h24, 32'h0, 1);
		check(u_host.nacks[7:0], 8'h03);
		check(modulation_control, m);
		$display("test wrong address done");
		// A reserved location is written on purpose; it stores nothing and must read zero after reset.
		wr(8'h30, 8'ha5);
		do_reset();
		rd(8'h30, 8'h00);
		rd(8'h22, 8'h30);
		rd(8'h24, 8'h00);
		rd(8'h20, {1'b0, dev[1:0], 5'h00});
		check({7'h00, defaults_valid}, 8'h00);
		$display("test reset restore done");
		complete_run();
	end
	// The full sequence needs about seventeen thousand clocks.
	initial begin
		repeat (80000) @(posedge clock);
		failures = failures + 1;
		complete_run();
	end
endmodule

// File: verif/tofcp_host.sv
/*
 * Two-wire bus master model, paced by the system clock.
 * Assumes the bench resolves the open-drain data line with a pull-up.
 */
`timescale 1ns/100ps
module tofcp_host (
	input  wire clock,	// Pacing clock.
	input  wire sda,	// Resolved data line.
	output reg  scl,	// Bus clock, idles high.
	output reg  sda_low	// High while pulling data low.
);
	integer nacks;
	// ====================
	// Bus phases
	// Four clocks a phase keep both clock spans above the bus minimum.
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		nacks = 0;
	end
	task tick(input integer n);
		repeat (n) @(posedge clock);
	endtask
	task bit_out(input b);
		sda_low <= !b;
		tick(4);
		scl <= 1'b1;
		tick(8);
		scl <= 1'b0;
		tick(4);
	endtask
	task bit_in(output b);
		sda_low <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(4);
		b = sda;
		tick(4);
		scl <= 1'b0;
		tick(4);
	endtask
	// Start and repeated start share one shape: data falls with the clock high.
	task start();
		sda_low <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sda_low <= 1'b1;
		tick(4);
		scl <= 1'b0;
		tick(4);
	endtask
	task stop();
		sda_low <= 1'b1;
		tick(4);
		scl <= 1'b1;
		tick(4);
		sda_low <= 1'b0;
		tick(8);
	endtask
	task byte_out(input [7:0] v);
		reg b;
		for (int j = 7; j >= 0; j--)
			bit_out(v[j]);
		bit_in(b);
		if (b !== 1'b0)
			nacks = nacks + 1;
	endtask
	// Register pointer first, then data bytes, so indirect access is one two-byte write.
	task write_seq(input [6:0] dev, input [7:0] ra, input [31:0] d, input integer n);
		start();
		byte_out({dev, 1'b0});
		byte_out(ra);
		for (int j = 0; j < n; j++)
			byte_out(d[8*j +: 8]);
		stop();
	endtask
	task read_seq(input [6:0] dev, input [7:0] ra, input integer n, output [31:0] d);
		reg [7:0] v;
		d = 32'h0;
		start();
		byte_out({dev, 1'b0});
		byte_out(ra);
		start();
		byte_out({dev, 1'b1});
		for (int j = 0; j < n; j++) begin
			for (int b = 7; b >= 0; b--)
				bit_in(v[b]);
			bit_out(j == n - 1);
			d[8*j +: 8] = v;
		end
		stop();
	endtask
endmodule

// File: verif/tofcp_regs_properties.sv
/*
 * Port checker for the control-page register bank.
 * Assumes it is bound to tofcp_regs and sees only its ports, on one clock.
 */
`timescale 1ns/100ps
module tofcp_regs_checker (
	input wire       clock,	// Clock.
	input wire       rst,	// Reset.
	input wire       scl_in,	// Bus clock pin.
	input wire       sda_oe,	// Data pull enable.
	input wire       sda_out,	// Data drive value.
	input wire       frame_active,	// Frame running.
	input wire       frame_start,	// Frame begins.
	input wire       program_loaded,	// Program in.
	input wire       nvm_load,	// Byte load pulse.
	input wire [7:0] nvm_load_data,	// Loaded byte.
	input wire [7:0] nvm_data,	// Data register.
	input wire       nvm_data_written,	// Write pulse.
	input wire [1:0] correlation_sample_first,	// First pair sample.
	input wire [1:0] correlation_sample_second,	// Second pair sample.
	input wire [1:0] background_suppression,	// Suppression code.
	input wire [7:0] modulation_control,	// Modulation in use.
	input wire       defaults_valid	// Defaults hold.
);
	// ====================
	// Properties
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// All shadowed outputs in one vector, so one check covers every field.
	wire [13:0] active_state = {modulation_control, background_suppression,
		correlation_sample_second, correlation_sample_first};
	property p_reset_state;
		$fell(rst) |-> !sda_oe && !defaults_valid && nvm_data == 8'h00 && active_state == 14'h0030;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
	property p_loaded;
		program_loaded && !frame_active |=> defaults_valid ##[0:1] active_state == 14'h0030;
	endproperty
	a_loaded: assert property (p_loaded) else $error("program load defaults wrong");
	property p_valid_cause;
		!program_loaded |=> defaults_valid == $past(defaults_valid);
	endproperty
	a_valid_cause: assert property (p_valid_cause) else $error("defaults flag moved");
	// A running frame keeps its settings until the next frame starts.
	property p_shadow_hold;
		(frame_active && !frame_start && !program_loaded) [*3] |-> $stable(active_state);
	endproperty
	a_shadow_hold: assert property (p_shadow_hold) else $error("setting changed mid-frame");
	property p_nvm_load;
		nvm_load |=> nvm_data == $past(nvm_load_data);
	endproperty
	a_nvm_load: assert property (p_nvm_load) else $error("loaded byte not stored");
	property p_nvm_pulse;
		nvm_data_written |=> !nvm_data_written;
	endproperty
	a_nvm_pulse: assert property (p_nvm_pulse) else $error("write pulse too long");
	// The device may only move the data line while the bus clock is low.
	property p_sda_scl_low;
		$changed(sda_oe) |-> !scl_in;
	endproperty
	a_sda_scl_low: assert property (p_sda_scl_low) else $error("data moved with clock high");
	property p_ack_width;
		$rose(sda_oe) |-> sda_oe [*8];
	endproperty
	a_ack_width: assert property (p_ack_width) else $error("data pull too short");
	// The data pin is open drain, so the device may only ever pull it low.
	property p_sda_out_low;
		sda_oe |-> !sda_out;
	endproperty
	a_sda_out_low: assert property (p_sda_out_low) else $error("data driven high");
endmodule
bind tofcp_regs tofcp_regs_checker u_checker (
	.clock(clock), .rst(rst), .scl_in(scl_in), .sda_oe(sda_oe), .sda_out(sda_out),
	.frame_active(frame_active),
	.frame_start(frame_start), .program_loaded(program_loaded), .nvm_load(nvm_load),
	.nvm_load_data(nvm_load_data), .nvm_data(nvm_data), .nvm_data_written(nvm_data_written),
	.correlation_sample_first(correlation_sample_first),
	.correlation_sample_second(correlation_sample_second),
	.background_suppression(background_suppression),
	.modulation_control(modulation_control), .defaults_valid(defaults_valid)
);
